// *** src/pe_status_pkg.sv ***
// Shared constants and types for the program/erase status block
package pe_status_pkg;

    // -----------------------------------------------------------------
    // Status word field positions
    // -----------------------------------------------------------------
    localparam int unsigned STATUS_WIDTH = 8;
    localparam int unsigned BIT_READY = 7;
    localparam int unsigned BIT_ERASE_SUSP = 6;
    localparam int unsigned BIT_ERASE_ERR = 5;
    localparam int unsigned BIT_PROG_ERR = 4;
    localparam int unsigned BIT_HV_ERR = 3;
    localparam int unsigned BIT_PROG_SUSP = 2;
    localparam int unsigned BIT_PROT_ERR = 1;
    localparam int unsigned BIT_RESERVED = 0;

    // -----------------------------------------------------------------
    // Reset values
    // -----------------------------------------------------------------
    localparam logic [7:0] STATUS_RESET = 8'h80;
    localparam logic RESERVED_VALUE = 1'b0;
    localparam logic READ_MODE_RESET = 1'b0;

    // -----------------------------------------------------------------
    // Pin synchroniser layout
    // -----------------------------------------------------------------
    localparam int unsigned SYNC_DEPTH = 3;
    localparam int unsigned PIN_COUNT = 4;
    localparam int unsigned PIN_CE_N = 0;
    localparam int unsigned PIN_OE_N = 1;
    localparam int unsigned PIN_INHIBIT_N = 2;
    localparam int unsigned PIN_HV_LOW = 3;
    // Chip, output enable and inhibit idle high, supply check idle low
    localparam logic [3:0] PIN_RESET = 4'h7;

    // -----------------------------------------------------------------
    // Controller states, Gray coded in the order listed below
    // -----------------------------------------------------------------
    typedef enum logic [2:0]
    {
        ST_IDLE = 3'h0,
        ST_PROG = 3'h1,
        ST_ERASE = 3'h3,
        ST_SUSPENDING = 3'h2,
        ST_PROG_SUSP = 3'h6,
        ST_ERASE_SUSP = 3'h7,
        ST_PROG_IN_ES = 3'h5
    } pe_state_t;

endpackage

// *** src/pin_sync.sv ***
// Three-stage pin synchroniser with agreement filter
module pin_sync #(
    parameter int unsigned WIDTH = 4,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Asynchronous pins
    input wire logic [WIDTH-1:0] pin_in,
    // Filtered level
    output logic [WIDTH-1:0] level_out
);

    logic [WIDTH-1:0] stage1_q;
    logic [WIDTH-1:0] stage2_q;
    logic [WIDTH-1:0] stage3_q;
    logic [WIDTH-1:0] level_q;
    logic [WIDTH-1:0] differ;

    // Only stage two and three are compared, stage one feeds stage two alone
    assign differ = stage2_q ^ stage3_q;

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            stage1_q <= RESET_VAL;
            stage2_q <= RESET_VAL;
            stage3_q <= RESET_VAL;
        end
        else
        begin
            stage1_q <= pin_in;
            stage2_q <= stage1_q;
            stage3_q <= stage2_q;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            level_q <= RESET_VAL;
        end
        else
        begin
            level_q <= (stage2_q & ~differ) | (level_q & differ);
        end
    end

    assign level_out = level_q;

endmodule

// *** src/pe_status.sv ***
// Program/erase controller status word and its presentation on the data lines
//
// Overview of operation
// - Status byte drives data lines seven to zero
// - Program, erase, resume enter status read mode
// - Status read mode ignores address inputs
// - Output re-enable refreshes presented status word
// - Bit seven zero busy, one ready
// - After suspend, bit seven zero until paused
// - Bit six marks suspended erase awaiting resume
// - Resume returns erase suspend bit to zero
// - Bit five flags erase verify failure
// - Bit four flags program verify failure
// - Supply checked at start, sets bit three
// - Bit two marks suspended program awaiting resume
// - Resume returns program suspend bit to zero
// - Bit one flags attempt on protected block
// - Protected block operation aborted, block untouched
// - Error bits sticky until clear or reset
// - Bit zero is reserved
// - Status read persists after pause until command
// - No commands accepted while suspend pending
module pe_status
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Bus control pins, asynchronous
    input wire logic chip_enable_n,
    input wire logic output_enable_n,
    input wire logic output_inhibit_n,
    // Supply monitor, high when below high_voltage_lockout_level
    input wire logic below_lockout_level,
    // Decoded command strobes, one cycle each
    input wire logic cmd_program,
    input wire logic cmd_erase,
    input wire logic cmd_suspend,
    input wire logic cmd_resume,
    input wire logic cmd_read_status,
    input wire logic cmd_clear_status,
    input wire logic cmd_read_other,
    input wire logic target_protected,
    output logic cmd_ready,
    // Program/erase algorithm engine
    output logic engine_start,
    output logic engine_is_erase,
    output logic engine_suspend,
    output logic engine_resume,
    input wire logic engine_done,
    input wire logic engine_paused,
    input wire logic engine_prog_fail,
    input wire logic engine_erase_fail,
    // Status data lines
    output logic [7:0] status_data_lines,
    output logic status_data_lines_oe,
    output logic status_read_mode
);

    // -----------------------------------------------------------------
    // Pin synchronisation
    // -----------------------------------------------------------------
    logic [pe_status_pkg::PIN_COUNT-1:0] pins_raw;
    logic [pe_status_pkg::PIN_COUNT-1:0] pins_sync;
    logic outputs_on;
    logic outputs_on_q;
    logic outputs_rise;
    logic hv_low;

    assign pins_raw[pe_status_pkg::PIN_CE_N] = chip_enable_n;
    assign pins_raw[pe_status_pkg::PIN_OE_N] = output_enable_n;
    assign pins_raw[pe_status_pkg::PIN_INHIBIT_N] = output_inhibit_n;
    assign pins_raw[pe_status_pkg::PIN_HV_LOW] = below_lockout_level;

    pin_sync #(
        .WIDTH(pe_status_pkg::PIN_COUNT),
        .RESET_VAL(pe_status_pkg::PIN_RESET)
    ) u_pin_sync (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .pin_in(pins_raw),
        .level_out(pins_sync)
    );

    assign outputs_on = !pins_sync[pe_status_pkg::PIN_CE_N]
        && !pins_sync[pe_status_pkg::PIN_OE_N]
        && pins_sync[pe_status_pkg::PIN_INHIBIT_N];
    assign hv_low = pins_sync[pe_status_pkg::PIN_HV_LOW];

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            outputs_on_q <= 1'b0;
        end
        else
        begin
            outputs_on_q <= outputs_on;
        end
    end

    // Any of the three pins going active again counts as a re-enable
    assign outputs_rise = outputs_on && !outputs_on_q;

    // -----------------------------------------------------------------
    // Command acceptance
    // -----------------------------------------------------------------
    pe_status_pkg::pe_state_t state_q;
    pe_status_pkg::pe_state_t state_d;
    logic erase_pending_q;
    logic start_ok;
    logic take_program;
    logic take_erase;
    logic take_suspend;
    logic take_resume;
    logic take_clear;
    logic take_read_status;
    logic take_read_other;
    logic idle_like;

    // Commands wait out the pause after a suspend
    assign cmd_ready = (state_q != pe_status_pkg::ST_SUSPENDING);

    assign idle_like = (state_q == pe_status_pkg::ST_IDLE)
        || (state_q == pe_status_pkg::ST_PROG_SUSP)
        || (state_q == pe_status_pkg::ST_ERASE_SUSP);

    // Protected target or low supply aborts before the engine runs
    assign start_ok = !target_protected && !hv_low;

    assign take_program = cmd_program
        && ((state_q == pe_status_pkg::ST_IDLE)
        || (state_q == pe_status_pkg::ST_ERASE_SUSP));
    assign take_erase = cmd_erase && (state_q == pe_status_pkg::ST_IDLE);
    assign take_suspend = cmd_suspend
        && ((state_q == pe_status_pkg::ST_PROG)
        || (state_q == pe_status_pkg::ST_ERASE));
    assign take_resume = cmd_resume
        && ((state_q == pe_status_pkg::ST_PROG_SUSP)
        || (state_q == pe_status_pkg::ST_ERASE_SUSP));
    assign take_clear = cmd_clear_status && cmd_ready;
    assign take_read_status = cmd_read_status && cmd_ready;
    assign take_read_other = cmd_read_other && idle_like;

    // -----------------------------------------------------------------
    // Controller state machine
    // -----------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            pe_status_pkg::ST_IDLE:
            begin
                if (take_program && start_ok)
                begin
                    state_d = pe_status_pkg::ST_PROG;
                end
                else if (take_erase && start_ok)
                begin
                    state_d = pe_status_pkg::ST_ERASE;
                end
            end
            pe_status_pkg::ST_PROG, pe_status_pkg::ST_ERASE:
            begin
                if (engine_done)
                begin
                    state_d = pe_status_pkg::ST_IDLE;
                end
                else if (take_suspend)
                begin
                    state_d = pe_status_pkg::ST_SUSPENDING;
                end
            end
            pe_status_pkg::ST_SUSPENDING:
            begin
                // The operation may finish instead of pausing
                if (engine_done)
                begin
                    state_d = pe_status_pkg::ST_IDLE;
                end
                else if (engine_paused)
                begin
                    state_d = erase_pending_q ? pe_status_pkg::ST_ERASE_SUSP
                        : pe_status_pkg::ST_PROG_SUSP;
                end
            end
            pe_status_pkg::ST_PROG_SUSP:
            begin
                if (take_resume)
                begin
                    state_d = pe_status_pkg::ST_PROG;
                end
            end
            pe_status_pkg::ST_ERASE_SUSP:
            begin
                if (take_resume)
                begin
                    state_d = pe_status_pkg::ST_ERASE;
                end
                else if (take_program && start_ok)
                begin
                    state_d = pe_status_pkg::ST_PROG_IN_ES;
                end
            end
            pe_status_pkg::ST_PROG_IN_ES:
            begin
                if (engine_done)
                begin
                    state_d = pe_status_pkg::ST_ERASE_SUSP;
                end
            end
            default:
            begin
                state_d = pe_status_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            state_q <= pe_status_pkg::ST_IDLE;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // Kind of the operation that a suspend would pause
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            erase_pending_q <= 1'b0;
        end
        else if (state_q == pe_status_pkg::ST_IDLE && state_d != pe_status_pkg::ST_IDLE)
        begin
            erase_pending_q <= (state_d == pe_status_pkg::ST_ERASE);
        end
    end

    // -----------------------------------------------------------------
    // Engine controls
    // -----------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            engine_start <= 1'b0;
            engine_is_erase <= 1'b0;
            engine_resume <= 1'b0;
        end
        else
        begin
            engine_start <= ((state_q == pe_status_pkg::ST_IDLE)
                || (state_q == pe_status_pkg::ST_ERASE_SUSP))
                && ((state_d == pe_status_pkg::ST_PROG)
                || (state_d == pe_status_pkg::ST_ERASE)
                || (state_d == pe_status_pkg::ST_PROG_IN_ES))
                && !take_resume;
            if (state_d == pe_status_pkg::ST_ERASE)
            begin
                engine_is_erase <= 1'b1;
            end
            else if (state_d == pe_status_pkg::ST_PROG || state_d == pe_status_pkg::ST_PROG_IN_ES)
            begin
                engine_is_erase <= 1'b0;
            end
            engine_resume <= take_resume;
        end
    end

    assign engine_suspend = (state_q == pe_status_pkg::ST_SUSPENDING);

    // -----------------------------------------------------------------
    // Sticky error flags, set wins over clear
    // -----------------------------------------------------------------
    logic erase_err_q;
    logic prog_err_q;
    logic hv_err_q;
    logic prot_err_q;
    logic start_try;

    // Supply and protection looked at only when an operation is started
    assign start_try = (take_program || take_erase) && !take_resume;

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            erase_err_q <= 1'b0;
            prog_err_q <= 1'b0;
            hv_err_q <= 1'b0;
            prot_err_q <= 1'b0;
        end
        else
        begin
            erase_err_q <= engine_erase_fail || (erase_err_q && !take_clear);
            prog_err_q <= engine_prog_fail || (prog_err_q && !take_clear);
            hv_err_q <= (start_try && hv_low) || (hv_err_q && !take_clear);
            prot_err_q <= (start_try && target_protected)
                || (prot_err_q && !take_clear);
        end
    end

    // -----------------------------------------------------------------
    // Status read mode
    // -----------------------------------------------------------------
    logic read_mode_q;

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            read_mode_q <= pe_status_pkg::READ_MODE_RESET;
        end
        else if (start_try || take_resume || take_suspend || take_read_status)
        begin
            read_mode_q <= 1'b1;
        end
        else if (take_read_other)
        begin
            read_mode_q <= 1'b0;
        end
    end

    assign status_read_mode = read_mode_q;

    // -----------------------------------------------------------------
    // Status word assembly and presentation
    // -----------------------------------------------------------------
    logic [7:0] status_word;
    logic [7:0] shown_q;

    always_comb
    begin
        status_word = '0;
        status_word[pe_status_pkg::BIT_READY] = idle_like;
        status_word[pe_status_pkg::BIT_ERASE_SUSP] =
            (state_q == pe_status_pkg::ST_ERASE_SUSP);
        status_word[pe_status_pkg::BIT_ERASE_ERR] = erase_err_q;
        status_word[pe_status_pkg::BIT_PROG_ERR] = prog_err_q;
        status_word[pe_status_pkg::BIT_HV_ERR] = hv_err_q;
        status_word[pe_status_pkg::BIT_PROG_SUSP] =
            (state_q == pe_status_pkg::ST_PROG_SUSP);
        status_word[pe_status_pkg::BIT_PROT_ERR] = prot_err_q;
        status_word[pe_status_pkg::BIT_RESERVED] =
            pe_status_pkg::RESERVED_VALUE;
    end

    // Snapshot taken each time the outputs are re-enabled
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            shown_q <= pe_status_pkg::STATUS_RESET;
        end
        else if (outputs_rise)
        begin
            shown_q <= status_word;
        end
    end

    // Address is not an input here: every read returns the word
    assign status_data_lines = shown_q;
    assign status_data_lines_oe = read_mode_q && outputs_on;

endmodule

// *** tb/pe_status_props.sv ***
// Port-level assertions for the program/erase status block
module pe_status_props
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Command side
    input wire logic below_lockout_level,
    input wire logic cmd_program,
    input wire logic cmd_erase,
    input wire logic target_protected,
    input wire logic cmd_ready,
    // Engine side
    input wire logic engine_start,
    input wire logic engine_suspend,
    input wire logic engine_resume,
    input wire logic engine_done,
    input wire logic engine_paused,
    // Data lines
    input wire logic [7:0] status_data_lines,
    input wire logic status_data_lines_oe,
    input wire logic status_read_mode
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    // -----------------------------------------------------------------
    // Properties
    // -----------------------------------------------------------------
    property p_start_mode;
        engine_start |-> status_read_mode && $past(cmd_program || cmd_erase);
    endproperty
    a_start_mode: assert property (p_start_mode) else $error("start without read mode");

    property p_start_pulse;
        engine_start |=> !engine_start;
    endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("start longer than one cycle");

    property p_resume_mode;
        engine_resume |-> status_read_mode;
    endproperty
    a_resume_mode: assert property (p_resume_mode) else $error("resume without read mode");

    property p_oe_mode;
        status_data_lines_oe |-> status_read_mode;
    endproperty
    a_oe_mode: assert property (p_oe_mode) else $error("lines driven outside read mode");

    property p_reserved;
        status_data_lines[0] == 1'b0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit not zero");

    property p_susp_lock;
        engine_suspend |-> !cmd_ready;
    endproperty
    a_susp_lock: assert property (p_susp_lock) else $error("commands open while suspending");

    property p_susp_hold;
        engine_suspend && !engine_paused && !engine_done |=> engine_suspend;
    endproperty
    a_susp_hold: assert property (p_susp_hold) else $error("suspend dropped before pause");

    property p_susp_end;
        engine_suspend && (engine_paused || engine_done) |=> !engine_suspend && cmd_ready;
    endproperty
    a_susp_end: assert property (p_susp_end) else $error("suspend held after pause");

    property p_prot_abort;
        (cmd_program || cmd_erase) && target_protected |=> !engine_start;
    endproperty
    a_prot_abort: assert property (p_prot_abort) else $error("protected target started");

    property p_hv_abort;
        (cmd_program || cmd_erase) && below_lockout_level && $past(below_lockout_level)
            && $past(below_lockout_level, 2) && $past(below_lockout_level, 3)
            && $past(below_lockout_level, 4) && $past(below_lockout_level, 5)
            |=> !engine_start;
    endproperty
    a_hv_abort: assert property (p_hv_abort) else $error("started with low supply");
endmodule

bind pe_status pe_status_props u_pe_status_props
(
    .sys_clk(sys_clk),
    .nrst(nrst),
    .below_lockout_level(below_lockout_level),
    .cmd_program(cmd_program),
    .cmd_erase(cmd_erase),
    .target_protected(target_protected),
    .cmd_ready(cmd_ready),
    .engine_start(engine_start),
    .engine_suspend(engine_suspend),
    .engine_resume(engine_resume),
    .engine_done(engine_done),
    .engine_paused(engine_paused),
    .status_data_lines(status_data_lines),
    .status_data_lines_oe(status_data_lines_oe),
    .status_read_mode(status_read_mode)
);

// *** tb/engine_model.sv ***
// Behavioural program/erase algorithm engine
module engine_model
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Requests from the status block
    input wire logic engine_start,
    input wire logic engine_is_erase,
    input wire logic engine_suspend,
    input wire logic engine_resume,
    // Scenario controls
    input wire logic fail_req,
    input wire logic finish_on_suspend,
    // Results
    output logic engine_done,
    output logic engine_paused,
    output logic engine_prog_fail,
    output logic engine_erase_fail
);
    timeunit 1ns;
    timeprecision 1ps;

    logic busy_q;
    logic kind_q;
    logic hold_q;
    logic park_q;
    int run_cnt;
    int susp_cnt;

    always_ff @(posedge sys_clk)
    begin
        engine_done <= 1'b0;
        engine_paused <= 1'b0;
        engine_prog_fail <= 1'b0;
        engine_erase_fail <= 1'b0;
        if (!nrst)
        begin
            busy_q <= 1'b0;
            kind_q <= 1'b0;
            hold_q <= 1'b0;
            park_q <= 1'b0;
            run_cnt <= 0;
            susp_cnt <= 0;
        end
        else if (engine_start)
        begin
            // A held erase is parked under the new program
            busy_q <= 1'b1;
            kind_q <= engine_is_erase;
            hold_q <= 1'b0;
            park_q <= hold_q;
            run_cnt <= 0;
            susp_cnt <= 0;
        end
        else if (engine_resume)
            hold_q <= 1'b0;
        else if (busy_q && !hold_q)
        begin
            // Pause or finish once the suspend latency has run out
            if (engine_suspend)
                susp_cnt <= susp_cnt + 1;
            else
                run_cnt <= run_cnt + 1;
            if ((engine_suspend && susp_cnt == 19 && finish_on_suspend) || run_cnt == 39)
            begin
                busy_q <= park_q;
                hold_q <= park_q;
                kind_q <= kind_q || park_q;
                park_q <= 1'b0;
                run_cnt <= 0;
                engine_done <= 1'b1;
                engine_prog_fail <= fail_req && !kind_q;
                engine_erase_fail <= fail_req && kind_q;
            end
            else if (engine_suspend && susp_cnt == 19)
            begin
                hold_q <= 1'b1;
                susp_cnt <= 0;
                engine_paused <= 1'b1;
            end
        end
    end
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the program/erase status block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [6:0] C_PROG = 7'h01;
    localparam logic [6:0] C_ERASE = 7'h02;
    localparam logic [6:0] C_SUSP = 7'h04;
    localparam logic [6:0] C_RES = 7'h08;
    localparam logic [6:0] C_RDST = 7'h10;
    localparam logic [6:0] C_CLR = 7'h20;
    localparam logic [6:0] C_OTHER = 7'h40;

    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic [2:0] pins_q = 3'h4;
    logic below_q = 1'b0;
    logic prot_q = 1'b0;
    logic [6:0] cmd_q = 7'h00;
    logic fail_q = 1'b0;
    logic finish_q = 1'b0;
    logic cmd_ready, engine_start, engine_is_erase, engine_suspend, engine_resume;
    logic engine_done, engine_paused, engine_prog_fail, engine_erase_fail;
    logic [7:0] status_data_lines;
    logic status_data_lines_oe, status_read_mode;
    int error_cnt = 0;
    int checks = 0;

    always #10 sys_clk = ~sys_clk;

    // -----------------------------------------------------------------
    // Design and engine
    // -----------------------------------------------------------------
    pe_status u_pe_status
    (
        .sys_clk(sys_clk), .nrst(nrst), .chip_enable_n(pins_q[0]),
        .output_enable_n(pins_q[1]), .output_inhibit_n(pins_q[2]),
        .below_lockout_level(below_q), .cmd_program(cmd_q[0]), .cmd_erase(cmd_q[1]),
        .cmd_suspend(cmd_q[2]), .cmd_resume(cmd_q[3]), .cmd_read_status(cmd_q[4]),
        .cmd_clear_status(cmd_q[5]), .cmd_read_other(cmd_q[6]),
        .target_protected(prot_q), .cmd_ready(cmd_ready), .engine_start(engine_start),
        .engine_is_erase(engine_is_erase), .engine_suspend(engine_suspend),
        .engine_resume(engine_resume), .engine_done(engine_done),
        .engine_paused(engine_paused), .engine_prog_fail(engine_prog_fail),
        .engine_erase_fail(engine_erase_fail), .status_data_lines(status_data_lines),
        .status_data_lines_oe(status_data_lines_oe), .status_read_mode(status_read_mode)
    );

    engine_model u_engine_model
    (
        .sys_clk(sys_clk), .nrst(nrst), .engine_start(engine_start),
        .engine_is_erase(engine_is_erase), .engine_suspend(engine_suspend),
        .engine_resume(engine_resume), .fail_req(fail_q), .finish_on_suspend(finish_q),
        .engine_done(engine_done), .engine_paused(engine_paused),
        .engine_prog_fail(engine_prog_fail), .engine_erase_fail(engine_erase_fail)
    );

    // -----------------------------------------------------------------
    // Shared tasks
    // -----------------------------------------------------------------
    task results();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task pulse(input logic [6:0] c);
        @(negedge sys_clk) cmd_q = c;
        @(negedge sys_clk) cmd_q = 7'h00;
    endtask

    // Re-enable the outputs through one pin, then take the fresh word
    task rd(input int pin, output logic [7:0] v);
        int i;
        @(negedge sys_clk) pins_q[pin] = (pin != 2);
        repeat (5) @(negedge sys_clk);
        pins_q[pin] = (pin == 2);
        for (i = 0; i < 12 && status_data_lines_oe !== 1'b1; i++)
            @(negedge sys_clk);
        if (i == 12)
        begin
            error_cnt++;
            $display("mismatch at %0t got %h expected %h", $time, 1'b0, 1'b1);
            results();
        end
        @(negedge sys_clk) v = status_data_lines;
    endtask

    // Poll the ready bit before looking at any other bit
    task poll(output logic [7:0] v);
        int i;
        for (i = 0; i < 10; i++)
        begin
            rd(1, v);
            if (v[7] === 1'b1)
                return;
        end
        error_cnt++;
        $display("mismatch at %0t got %h expected %h", $time, v, 8'h80);
        results();
    endtask

    // -----------------------------------------------------------------
    // Scenarios
    // -----------------------------------------------------------------
    task t_mode();
        logic [7:0] v;
        chk(status_data_lines, pe_status_pkg::STATUS_RESET);
        chk({5'h00, status_read_mode, status_data_lines_oe, cmd_ready}, 8'h01);
        pulse(C_RDST);
        repeat (4) @(negedge sys_clk);
        chk({7'h00, status_data_lines_oe}, 8'h01);
        pulse(C_OTHER);
        chk({7'h00, status_data_lines_oe}, 8'h00);
        pulse(C_RDST);
        for (int p = 0; p < 3; p++)
        begin
            rd(p, v);
            chk(v, 8'h80);
        end
    endtask

    task t_op(input logic [6:0] c, input logic f, input logic [7:0] busy, input logic [7:0] fin);
        logic [7:0] v;
        fail_q = f;
        pulse(c);
        rd(1, v);
        chk(v, busy);
        poll(v);
        chk(v, fin);
        fail_q = 1'b0;
    endtask

    task t_susp(input logic [6:0] c, input logic fin, input logic [7:0] exp);
        logic [7:0] v;
        finish_q = fin;
        pulse(c);
        pulse(C_SUSP);
        chk({7'h00, cmd_ready}, 8'h00);
        rd(0, v);
        chk(v, 8'h00);
        poll(v);
        chk(v, exp);
        if (!fin)
        begin
            if (exp[6])
            begin
                pulse(C_PROG);
                rd(1, v);
                chk(v, 8'h00);
                poll(v);
                chk(v, 8'hC0);
            end
            pulse(C_RES);
            rd(2, v);
            chk(v, 8'h00);
            poll(v);
            chk(v, 8'h80);
        end
        finish_q = 1'b0;
    endtask

    task t_abort();
        logic [7:0] v;
        @(negedge sys_clk) prot_q = 1'b1;
        pulse(C_PROG);
        prot_q = 1'b0;
        rd(2, v);
        chk(v, 8'h82);
        pulse(C_CLR);
        rd(0, v);
        chk(v, 8'h80);
        below_q = 1'b1;
        repeat (6) @(negedge sys_clk);
        pulse(C_ERASE);
        below_q = 1'b0;
        rd(1, v);
        chk(v, 8'h88);
        pulse(C_CLR);
        rd(1, v);
        chk(v, 8'h80);
    endtask

    // -----------------------------------------------------------------
    // Main sequence
    // -----------------------------------------------------------------
    initial
    begin
        repeat (8) @(negedge sys_clk);
        nrst = 1'b1;
        @(negedge sys_clk);
        t_mode();
        t_op(C_PROG, 1'b0, 8'h00, 8'h80);
        t_op(C_ERASE, 1'b1, 8'h00, 8'hA0);
        t_op(C_PROG, 1'b1, 8'h20, 8'hB0);
        pulse(C_CLR);
        t_op(C_ERASE, 1'b0, 8'h00, 8'h80);
        t_susp(C_PROG, 1'b0, 8'h84);
        t_susp(C_ERASE, 1'b0, 8'hC0);
        t_susp(C_PROG, 1'b1, 8'h80);
        t_abort();
        results();
    end
endmodule
